// ==== pkg/fiber_pkg.sv ====
// package: register map, field positions and types for the fiber mode block
package fiber_pkg;
  localparam logic [4:0] ADR_BMCR   = 5'h00;
  localparam logic [4:0] ADR_BMSR   = 5'h01;
  localparam logic [4:0] ADR_PHY_SUMMARY_STATUS = 5'h10;
  localparam logic [4:0] ADR_PCS_CONFIG_REG   = 5'h16;
  localparam logic [4:0] ADR_LBR    = 5'h17;
  localparam logic [4:0] ADR_PHYCTL = 5'h19;
  localparam int BIT_AN_EN      = 12;
  localparam int BIT_FAR_FAULT  = 4;
  localparam int BIT_SUM_FAULT  = 7;
  localparam int BIT_FSEL       = 5;
  localparam int BIT_FF_EN      = 14;
  localparam int BIT_SD_BIAS    = 15;
  localparam int BIT_BYPASS     = 11;
  localparam int LBR_MODE_LO    = 7;
  localparam logic [2:0] LBR_MODE_FX = 3'h3;
  localparam logic [15:0] BMCR_RST   = 16'h1000;
  localparam logic [15:0] PCS_CONFIG_REG_RST   = 16'h0000;
  localparam logic [15:0] LBR_RST    = 16'h0000;
  localparam logic [15:0] PHYCTL_RST = 16'h0000;
  localparam int ONES_RUN        = 84;
  localparam int FAULT_PATTERNS  = 3;
  localparam logic [6:0] ONES_RUN_W = 7'(ONES_RUN);
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic        tx_en;
    logic        tx_er;
    logic        rx_dv;
    logic        rx_er;
    logic        crs;
  } mii_ctl_t;
endpackage

// ==== rtl/fiber_mode_far_end_fault.sv ====
// fiber mode path select, far end fault idle generation and detection
// Notes on behaviour
// - fiber mode disables twisted pair path
// - fiber transmit sends nrzi, scrambler bypassed
// - fiber receive takes nrzi, descrambler bypassed
// - fault idle: 84 ones then one zero
// - fault idle until signal detect returns
// - three patterns set status bit until read
// - same detection sets summary status bit
// - first pattern may hold extra ones
// - fault idle never raises carrier sense
// - enable cleared means no fault idle
// - fault detected blocks mii activity
// - auto-negotiation forces fault signalling off
// - fiber mode enables fault signalling automatically
// - control bit selects fiber like strap
// - pcs config bit enables fault signalling
// - loop bypass bit 11 bypasses scrambling
// - pcs bit generates signal detect bias
`timescale 1ns/1ps
`default_nettype none
module fiber_mode_far_end_fault #(
  parameter int PAT_COUNT = fiber_pkg::FAULT_PATTERNS
) (
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  input  wire fiber_pkg::wb_req_t  wb_req_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                fiber_select_strap_n_i,
  input  wire logic                fiber_sig_detect_i,
  input  wire logic                fiber_rx_pair_i,
  output logic                     fiber_tx_pair_o,
  input  wire logic                tx_code_bit_i,
  input  wire logic                tx_idle_i,
  output logic                     rx_code_bit_o,
  output logic                     tp_enable_o,
  output logic                     scramble_bypass_o,
  output logic                     sd_bias_en_o,
  output logic                     signal_detect_o,
  input  wire fiber_pkg::mii_ctl_t mii_i,
  output fiber_pkg::mii_ctl_t      mii_o
);
  import fiber_pkg::*;

  typedef struct packed {
    logic        strap_done;
    logic        strap_fx;
    logic [15:0] bmcr;
    logic [15:0] pcs_config_reg;
    logic [15:0] loop_bypass_reg;
    logic [15:0] phyctl;
    logic        far_fault;
    logic        fault_live;
    logic        ack;
    logic [31:0] rdat;
    logic        tx_nrzi;
    logic [6:0]  tx_cnt;
    logic        rx_prev;
    logic        rx_bit;
    logic [6:0]  ones;
    logic        long_ok;
    logic [1:0]  pats;
    logic [6:0]  gap;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic fiber_mode;
  logic ff_active;
  logic ff_send;
  logic tx_sym;
  logic rx_sym;
  logic rd_strobe;
  logic wr_strobe;
  logic [15:0] bmsr_val;
  logic [15:0] phy_summary_status_val;

  function automatic logic [15:0] wr_merge(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
    logic [15:0] m;
    m = old;
    if (sel[0]) begin
      m[7:0] = d[7:0];
    end
    if (sel[1]) begin
      m[15:8] = d[15:8];
    end
    return m;
  endfunction

  always_comb begin
    fiber_mode = st_r.strap_fx | st_r.phyctl[BIT_FSEL];
    // fault signalling needs fiber mode, the pcs enable bit set and auto-negotiation off
    ff_active  = fiber_mode & st_r.pcs_config_reg[BIT_FF_EN] & ~st_r.bmcr[BIT_AN_EN];
    ff_send    = ff_active & ~fiber_sig_detect_i & tx_idle_i;
    if (ff_send) begin
      tx_sym = (st_r.tx_cnt != ONES_RUN_W);
    end else begin
      tx_sym = tx_code_bit_i;
    end
    rx_sym     = fiber_rx_pair_i ^ st_r.rx_prev;
    rd_strobe  = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~st_r.ack;
    wr_strobe  = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~st_r.ack;
    bmsr_val   = '0;
    bmsr_val[BIT_FAR_FAULT] = st_r.far_fault;
    phy_summary_status_val = '0;
    phy_summary_status_val[BIT_SUM_FAULT] = st_r.fault_live;
  end

  always_comb begin
    st_nxt = st_r;
    // strap sampled on the first clock after reset release
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.strap_fx   = ~fiber_select_strap_n_i;
    end
    // tx: nrzi toggle on each one, no scrambler in the path
    st_nxt.tx_nrzi = st_r.tx_nrzi ^ tx_sym;
    if (ff_send) begin
      st_nxt.tx_cnt = (st_r.tx_cnt == ONES_RUN_W) ? 7'h00 : st_r.tx_cnt + 7'h01;
    end else begin
      st_nxt.tx_cnt = 7'h00;
    end
    // rx: nrzi decode then fault pattern detector
    st_nxt.rx_prev = fiber_rx_pair_i;
    st_nxt.rx_bit  = rx_sym;
    if (fiber_mode) begin
      if (rx_sym) begin
        if (st_r.ones != 7'h7F) begin
          st_nxt.ones = st_r.ones + 7'h01;
        end
      end else begin
        st_nxt.ones = 7'h00;
        // exact 84 after the first pattern; longer runs only start one
        if ((st_r.ones == ONES_RUN_W) || (st_r.ones > ONES_RUN_W && st_r.pats == 2'h0)) begin
          if (st_r.pats != 2'h3) begin
            st_nxt.pats = st_r.pats + 2'h1;
          end
        end else begin
          st_nxt.pats = 2'h0;
        end
      end
    end else begin
      st_nxt.ones = 7'h00;
      st_nxt.pats = 2'h0;
    end
    st_nxt.fault_live = (st_nxt.pats >= 2'(PAT_COUNT));
    st_nxt.long_ok    = 1'b0;
    st_nxt.gap        = 7'h00;
    // wishbone slave: one wait state, ack for one cycle
    st_nxt.ack  = rd_strobe | wr_strobe;
    st_nxt.rdat = st_r.rdat;
    if (rd_strobe) begin
      unique case (wb_req_i.adr[6:2])
        ADR_BMCR:   st_nxt.rdat = {16'h0000, st_r.bmcr};
        ADR_BMSR:   st_nxt.rdat = {16'h0000, bmsr_val};
        ADR_PHY_SUMMARY_STATUS: st_nxt.rdat = {16'h0000, phy_summary_status_val};
        ADR_PCS_CONFIG_REG:   st_nxt.rdat = {16'h0000, st_r.pcs_config_reg};
        ADR_LBR:    st_nxt.rdat = {16'h0000, st_r.loop_bypass_reg};
        ADR_PHYCTL: st_nxt.rdat = {16'h0000, st_r.phyctl};
        default:    st_nxt.rdat = 32'h0000_0000;
      endcase
    end
    if (wr_strobe) begin
      unique case (wb_req_i.adr[6:2])
        ADR_BMCR:   st_nxt.bmcr   = wr_merge(st_r.bmcr, wb_req_i.dat, wb_req_i.sel);
        ADR_PCS_CONFIG_REG:   st_nxt.pcs_config_reg   = wr_merge(st_r.pcs_config_reg, wb_req_i.dat, wb_req_i.sel);
        ADR_LBR:    st_nxt.loop_bypass_reg    = wr_merge(st_r.loop_bypass_reg, wb_req_i.dat, wb_req_i.sel);
        ADR_PHYCTL: st_nxt.phyctl = wr_merge(st_r.phyctl, wb_req_i.dat, wb_req_i.sel);
        default:    st_nxt.bmcr   = st_r.bmcr;
      endcase
    end
    // fiber select enables fault signalling once, software may clear it
    if (fiber_mode && !(st_r.strap_fx | st_r.phyctl[BIT_FSEL])) begin
      st_nxt.pcs_config_reg[BIT_FF_EN] = 1'b1;
    end
    if (st_nxt.phyctl[BIT_FSEL] && !st_r.phyctl[BIT_FSEL] && !wr_strobe) begin
      st_nxt.pcs_config_reg[BIT_FF_EN] = 1'b1;
    end
    if ((st_nxt.strap_fx && !st_r.strap_fx) ||
        (wr_strobe && wb_req_i.adr[6:2] == ADR_PHYCTL && wb_req_i.dat[BIT_FSEL] &&
         !st_r.phyctl[BIT_FSEL] && wb_req_i.sel[0])) begin
      st_nxt.pcs_config_reg[BIT_FF_EN] = 1'b1;
    end
    // read of a set bit clears it; a new detection in that cycle wins
    if (rd_strobe && wb_req_i.adr[6:2] == ADR_BMSR) begin
      st_nxt.far_fault = 1'b0;
    end
    if (st_nxt.fault_live && !st_r.fault_live) begin
      st_nxt.far_fault = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r        <= '0;
      st_r.bmcr   <= BMCR_RST;
      st_r.pcs_config_reg   <= PCS_CONFIG_REG_RST;
      st_r.loop_bypass_reg    <= LBR_RST;
      st_r.phyctl <= PHYCTL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    wb_dat_o          = st_r.rdat;
    wb_ack_o          = st_r.ack;
    fiber_tx_pair_o   = st_r.tx_nrzi;
    rx_code_bit_o     = st_r.rx_bit;
    tp_enable_o       = ~fiber_mode;
    // either bypass bit or fiber mode skips the scrambler
    scramble_bypass_o = fiber_mode | st_r.loop_bypass_reg[BIT_BYPASS];
    sd_bias_en_o      = st_r.pcs_config_reg[BIT_SD_BIAS];
    signal_detect_o   = fiber_mode & fiber_sig_detect_i;
    mii_o             = mii_i;
    // mii gated while fault is seen; management path untouched
    if (st_r.fault_live) begin
      mii_o = '0;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/fiber_mode_far_end_fault_tb.sv ====
// bench for the fiber mode block
`timescale 1ns/1ps
`default_nettype none
module fiber_mode_far_end_fault_tb;
  import fiber_pkg::*;
  logic mclk_i, rst_i, sd, sdl, rxp, txp, txb, txi, rxb, tp, byp, bias, sdo, ack, strap_n;
  logic [1:0] mode;
  logic [31:0] dat;
  logic [15:0] rd;
  wb_req_t req;
  mii_ctl_t mii_in, mii_out;
  int err_count, comparisons, n;
  initial begin
    mclk_i = 0;
    forever #20 mclk_i = ~mclk_i;
  end
  fiber_mode_far_end_fault dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_dat_o(dat), .wb_ack_o(ack), .fiber_select_strap_n_i(strap_n),
    .fiber_sig_detect_i(sdl), .fiber_rx_pair_i(rxp), .fiber_tx_pair_o(txp),
    .tx_code_bit_i(txb), .tx_idle_i(txi), .rx_code_bit_o(rxb), .tp_enable_o(tp),
    .scramble_bypass_o(byp), .sd_bias_en_o(bias), .signal_detect_o(sdo),
    .mii_i(mii_in), .mii_o(mii_out));
  fiber_xcvr xcvr_u (.mclk_i(mclk_i), .rst_i(rst_i), .mode_i(mode), .sd_i(sd),
    .rx_pair_o(rxp), .sd_o(sdl));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [4:0] off, input logic [15:0] wd,
                     output logic [15:0] q);
    int k;
    @(posedge mclk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: {1'b0, off, 2'b00}, dat: {16'h0, wd}};
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = dat[15:0];
    req <= '0;
    if (k >= 20) chk(16'h0000, 16'h0001);
  endtask
  // length of the ones run between two line zeros, -1 if none in 400 cycles
  task automatic run_len(output int len);
    int c, st;
    logic p;
    len = -1;
    st = 0;
    c = 0;
    p = txp;
    for (int i = 0; i < 400 && st < 2; i++) begin
      @(posedge mclk_i);
      if ((txp ^ p) === 1'b0) begin
        if (st == 1) len = c;
        st++;
        c = 0;
      end else c++;
      p = txp;
    end
  endtask
  task automatic stop_test;
    $display("counts: %0d mismatches, %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #1000000;
    err_count++;
    stop_test();
  end
  initial begin
    rst_i = 1;
    req = '0;
    mii_in = '0;
    mode = 2'h0;
    strap_n = 1;
    sd = 1;
    txb = 1;
    txi = 1;
    err_count = 0;
    comparisons = 0;
    repeat (6) @(posedge mclk_i);
    rst_i <= 0;
    repeat (2) @(posedge mclk_i);
    chk({15'h0, tp}, 16'h0001);
    bus(0, ADR_BMCR, 16'h0, rd); chk(rd, BMCR_RST);
    bus(0, 5'h1F, 16'h0, rd); chk(rd, 16'h0000);
    bus(1, ADR_PHYCTL, 16'h0020, rd); chk({15'h0, tp}, 16'h0000);
    bus(0, ADR_PCS_CONFIG_REG, 16'h0, rd); chk(rd, 16'h4000);
    bus(1, ADR_LBR, 16'h0980, rd); chk({15'h0, byp}, 16'h0001);
    bus(0, ADR_LBR, 16'h0, rd); chk(rd, 16'h0980);
    $display("test config done");
    sd <= 0;
    run_len(n); chk(16'(n), 16'hFFFF);
    chk({15'h0, sdo}, 16'h0000);
    bus(1, ADR_BMCR, 16'h0, rd); run_len(n); chk(16'(n), 16'h0054);
    sd <= 1;
    run_len(n);
    run_len(n); chk(16'(n), 16'hFFFF);
    bus(1, ADR_PCS_CONFIG_REG, 16'h8000, rd); chk({15'h0, bias}, 16'h0001);
    sd <= 0;
    run_len(n); chk(16'(n), 16'hFFFF);
    sd <= 1;
    bus(1, ADR_PCS_CONFIG_REG, 16'h4000, rd);
    $display("test transmit done");
    mii_in <= '1;
    mode <= 2'h1;
    repeat (400) @(posedge mclk_i);
    chk({11'h0, mii_out}, 16'h0000);
    bus(0, ADR_PHY_SUMMARY_STATUS, 16'h0, rd); chk(rd & 16'h0080, 16'h0080);
    mode <= 2'h2;
    repeat (100) @(posedge mclk_i);
    chk({11'h0, mii_out}, 16'h001F);
    bus(0, ADR_BMSR, 16'h0, rd); chk(rd & 16'h0010, 16'h0010);
    bus(0, ADR_BMSR, 16'h0, rd); chk(rd & 16'h0010, 16'h0000);
    bus(0, ADR_PHY_SUMMARY_STATUS, 16'h0, rd); chk(rd & 16'h0080, 16'h0000);
    txi <= 0;
    repeat (20) begin
      @(posedge mclk_i);
      txb <= ~txb;
    end
    txi <= 1;
    $display("test receive done");
    // second reset with the strap low: fiber from the strap alone
    strap_n <= 0;
    rst_i <= 1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 0;
    repeat (2) @(posedge mclk_i);
    chk({15'h0, tp}, 16'h0000);
    bus(0, ADR_PCS_CONFIG_REG, 16'h0, rd); chk(rd, 16'h4000);
    $display("test strap done");
    stop_test();
  end
endmodule
`default_nettype wire

// ==== testbench/fiber_props.sv ====
// checker: port relations of the fiber mode block
`timescale 1ns/1ps
`default_nettype none
module fiber_props
  import fiber_pkg::*;
#(parameter int PAT_COUNT = FAULT_PATTERNS) (
  input wire logic     mclk_i,
  input wire logic     rst_i,
  input wire wb_req_t  wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic     wb_ack_o,
  input wire logic     fiber_sig_detect_i,
  input wire logic     fiber_rx_pair_i,
  input wire logic     fiber_tx_pair_o,
  input wire logic     tx_code_bit_i,
  input wire logic     tx_idle_i,
  input wire logic     rx_code_bit_o,
  input wire logic     tp_enable_o,
  input wire logic     signal_detect_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic req;
  assign req = wb_req_i.cyc & wb_req_i.stb;
  a_ack_one_cycle: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper");
  a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("data moved");
  a_sd_follow: assert property (signal_detect_o == (!tp_enable_o && fiber_sig_detect_i))
    else $error("signal detect wrong");
  a_tx_line_code: assert property (!tp_enable_o && !tx_idle_i |=>
    fiber_tx_pair_o == ($past(fiber_tx_pair_o) ^ $past(tx_code_bit_i))) else $error("tx code");
  a_rx_line_code: assert property (!tp_enable_o && $past(tp_enable_o) == 1'b0 |->
    rx_code_bit_o == ($past(fiber_rx_pair_i) ^ $past(fiber_rx_pair_i, 2))) else $error("rx code");
  cover property (wb_ack_o && wb_req_i.we);
  cover property (!tp_enable_o && !fiber_sig_detect_i);
  cover property ($fell(signal_detect_o));
endmodule
bind fiber_mode_far_end_fault fiber_props #(.PAT_COUNT(PAT_COUNT)) props_u (
  .mclk_i(mclk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .fiber_sig_detect_i(fiber_sig_detect_i),
  .fiber_rx_pair_i(fiber_rx_pair_i), .fiber_tx_pair_o(fiber_tx_pair_o),
  .tx_code_bit_i(tx_code_bit_i), .tx_idle_i(tx_idle_i), .rx_code_bit_o(rx_code_bit_o),
  .tp_enable_o(tp_enable_o), .signal_detect_o(signal_detect_o));
`default_nettype wire

// ==== testbench/fiber_xcvr.sv ====
// far side model: optical transceiver line and signal detect
`timescale 1ns/1ps
`default_nettype none
module fiber_xcvr (
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic [1:0] mode_i,
  input wire logic       sd_i,
  output logic           rx_pair_o,
  output logic           sd_o
);
  logic [6:0] cnt_r;
  logic       bit_w;
  assign sd_o = sd_i;
  // mode 1 fault idle, mode 2 zeros too early to form a pattern
  always_comb begin
    bit_w = 1'b1;
    if (mode_i == 2'h1) bit_w = (cnt_r != 7'h54);
    if (mode_i == 2'h2) bit_w = (cnt_r[3:0] != 4'h9);
  end
  // pattern starts mid idle, so its first run is long
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 7'h00;
      rx_pair_o <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 7'h54) ? 7'h00 : cnt_r + 7'h01;
      rx_pair_o <= rx_pair_o ^ bit_w;
    end
  end
endmodule
`default_nettype wire
